// ==== rtcpt_top.sv ====
// real-time counter with prescaler, compare, period and periodic tick
// clock sources arrive as pins and are sampled on clk; config is plain ports
// How it works
// - count ticks; compare flag after equal count
// - overflow flag on count after period match
// - overflow returns counter to zero
// - four selectable counter clock sources
// - fifteen-bit prescaler divides the reference clock
// - correction of 1 ppm steps, 127 max setting, at most 123 applied per window
// - correction skips or inserts prescaler counts
// - periodic tick, powers of two, level events
// - periodic tick enabled independently of counter
// - counter enable bit starts and stops counter
// - periodic enable bit starts and stops tick
// - both functions share one prescaler counter
// - prescaler cleared to zero while both enables low
// - first tick phase anywhere within one period
// - periodic output toggles every half period
// - sixteen-cycle setting follows prescaler bit three
// - request while enable and flag set
`default_nettype none
`include "rtcpt_params.svh"
module rtcpt_top (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // counter clock source pins
    input  wire logic                         xtal_clk,
    input  wire logic                         ext_clk,
    input  wire logic                         low_power_osc,
    input  wire rtcpt_pkg::rtcpt_src_t        clock_source_select,
    // counter configuration
    input  wire logic                         counter_enable_bit,
    input  wire logic [`RTCPT_PRESC_W-1:0]    prescaler_sel,
    input  wire logic [`RTCPT_CNT_W-1:0]      compare_value,
    input  wire logic [`RTCPT_CNT_W-1:0]      period_value,
    input  wire logic                         compare_irq_enable,
    input  wire logic                         overflow_irq_enable,
    input  wire logic                         correction_enable,
    input  wire logic [`RTCPT_CAL_W-1:0]      correction_ppm,
    // periodic tick configuration
    input  wire logic                         periodic_enable_bit,
    input  wire logic [`RTCPT_PERIOD_W-1:0]   periodic_period_sel,
    input  wire logic [`RTCPT_PERIOD_W-1:0]   periodic_event_sel,
    input  wire logic                         periodic_irq_enable,
    // flag clears, write one to clear
    input  wire logic                         compare_flag_clear,
    input  wire logic                         overflow_flag_clear,
    input  wire logic                         periodic_flag_clear,
    // status and requests
    output var  logic [`RTCPT_CNT_W-1:0]      count_value,
    output var  logic                         compare_flag,
    output var  logic                         overflow_flag,
    output var  logic                         periodic_flag,
    output var  logic                         counter_irq,
    output var  logic                         periodic_irq,
    output var  logic                         compare_event,
    output var  logic                         overflow_event,
    output var  logic                         periodic_event,
    output var  logic                         counter_running
);
    import rtcpt_pkg::*;

    logic [2:0]                  src_sync;
    logic                        src_lvl;
    logic                        src_prev;
    logic                        ref_edge;
    logic [4:0]                  osc_div;
    logic                        osc_slow;
    logic [`RTCPT_PRE_W-1:0]     pre_cnt;
    logic [`RTCPT_PRE_W-1:0]     next_pre_cnt;
    logic                        pre_run;
    logic                        pre_step;
    logic                        cnt_tick;
    logic [`RTCPT_CNT_W-1:0]     cnt;
    logic                        cmp_hit;
    logic                        ovf_hit;
    logic                        pit_lvl;
    logic                        pit_prev;
    logic                        pit_rise;
    logic [19:0]                 corr_win;
    logic [6:0]                  corr_done;
    logic [6:0]                  corr_mag;
    logic                        corr_slow;
    logic                        corr_skip;
    logic                        corr_hold;
    logic                        corr_extra;
    logic                        pre_adv;
    rtcpt_corr_t                 corr_st;

    // selects bit of prescaler counter: code k taps bit k, period 2^(k+1)
    function automatic logic tap_bit(input logic [`RTCPT_PRE_W-1:0] v,
                                     input logic [`RTCPT_PERIOD_W-1:0] k);
        tap_bit = v[k];
    endfunction

    // crystal and external clocks come from pins; the oscillator
    // divide by 32 runs on the synchronised oscillator edges
    rtcpt_sync #(.W(3)) u_src_sync (
        .clk (clk),
        .rst (rst),
        .d   ({xtal_clk, ext_clk, low_power_osc}),
        .q   (src_sync)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_div  <= 5'h00;
            osc_slow <= 1'b0;
        end else if (src_sync[0] && !osc_slow) begin
            osc_slow <= 1'b1;
            osc_div  <= osc_div + 5'h01;
        end else if (!src_sync[0]) begin
            osc_slow <= 1'b0;
        end
    end

    // source mux; a change of source may give one stray edge
    always_comb begin
        unique case (clock_source_select)
            RTCPT_SRC_XTAL:  src_lvl = src_sync[2];
            RTCPT_SRC_EXT:   src_lvl = src_sync[1];
            RTCPT_SRC_ULP:   src_lvl = src_sync[0];
            RTCPT_SRC_ULP32: src_lvl = osc_div[4];
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= src_lvl;
        end
    end
    assign ref_edge = src_lvl && !src_prev;

    // correction: spread corr_mag adjustments, at most 123, through a million cycles;
    // an ongoing window is finished even if correction is switched off
    assign corr_mag = correction_ppm[7] ? 7'(-correction_ppm[6:0]) : correction_ppm[6:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            corr_st   <= RTCPT_C_IDLE;
            corr_win  <= 20'h00000;
            corr_done <= 7'h00;
            corr_slow <= 1'b0;
        end else if (ref_edge && pre_run) begin
            unique case (corr_st)
                RTCPT_C_IDLE: begin
                    if (correction_enable && corr_mag != 7'h00) begin
                        corr_st   <= RTCPT_C_APPLY;
                        corr_slow <= correction_ppm[7];
                        corr_win  <= 20'h00000;
                        corr_done <= 7'h00;
                    end
                end
                RTCPT_C_APPLY: begin
                    corr_win <= corr_win + 20'h00001;
                    if (corr_done != corr_mag && corr_win[12:0] == 13'h0000) begin
                        corr_done <= corr_done + 7'h01;
                    end
                    if (corr_win == `RTCPT_CORR_WIN) begin
                        corr_st <= RTCPT_C_WAIT;
                    end
                end
                RTCPT_C_WAIT: begin
                    corr_st <= RTCPT_C_IDLE;
                end
                default: corr_st <= RTCPT_C_IDLE;
            endcase
        end
    end

    // one adjustment per 8192-cycle slot while quota remains
    assign corr_skip = (corr_st == RTCPT_C_APPLY) && (corr_done != corr_mag)
                       && (corr_win[12:0] == 13'h0000);
    // slow: this input edge is swallowed; fast: one extra step follows it
    assign corr_hold = corr_skip && corr_slow;

    assign pre_run  = counter_enable_bit || periodic_enable_bit;
    assign pre_step = ref_edge && pre_run && !corr_hold;
    assign pre_adv  = pre_step || (corr_extra && pre_run);

    // fast: extra step in the cycle after the edge, never on an edge;
    // a jump by two would hide a rise of bit 0 and slow the counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            corr_extra <= 1'b0;
        end else begin
            corr_extra <= pre_step && corr_skip && !corr_slow;
        end
    end

    always_comb begin
        next_pre_cnt = pre_cnt;
        if (!pre_run) begin
            next_pre_cnt = `RTCPT_PRE_RST;
        end else if (pre_adv) begin
            next_pre_cnt = pre_cnt + 15'h0001;
        end
    end

    // single shared prescaler counter for both functions
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_cnt <= `RTCPT_PRE_RST;
        end else begin
            pre_cnt <= next_pre_cnt;
        end
    end

    // counter tick on every prescaler step at setting 0, else when the prescaler bit for the selected divider
    // rises; phase relative to enable is free, as it should be
    always_comb begin
        if (prescaler_sel == 4'h0) begin
            cnt_tick = pre_adv;
        end else begin
            cnt_tick = next_pre_cnt[prescaler_sel - 4'h1] && !pre_cnt[prescaler_sel - 4'h1]
                       && pre_run;
        end
    end

    assign cmp_hit = cnt_tick && counter_enable_bit && (cnt == compare_value);
    assign ovf_hit = cnt_tick && counter_enable_bit && (cnt == period_value);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= `RTCPT_CNT_RST;
        end else if (ovf_hit) begin
            cnt <= `RTCPT_CNT_RST;
        end else if (cnt_tick && counter_enable_bit) begin
            cnt <= cnt + 16'h0001;
        end
    end

    // periodic output is a prescaler bit: toggles each half period
    always_comb begin
        if (periodic_enable_bit && periodic_period_sel >= `RTCPT_PER_MIN
            && periodic_period_sel <= `RTCPT_PER_MAX) begin
            pit_lvl = tap_bit(pre_cnt, periodic_period_sel);
        end else begin
            pit_lvl = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pit_prev <= 1'b0;
        end else begin
            pit_prev <= pit_lvl;
        end
    end
    assign pit_rise = pit_lvl && !pit_prev;

    // sticky flags: a set in the same cycle as its clear wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_flag  <= 1'b0;
            overflow_flag <= 1'b0;
            periodic_flag <= 1'b0;
        end else begin
            compare_flag  <= cmp_hit  || (compare_flag  && !compare_flag_clear);
            overflow_flag <= ovf_hit  || (overflow_flag && !overflow_flag_clear);
            periodic_flag <= pit_rise || (periodic_flag && !periodic_flag_clear);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            counter_irq  <= 1'b0;
            periodic_irq <= 1'b0;
        end else begin
            counter_irq  <= (compare_irq_enable && (cmp_hit || (compare_flag && !compare_flag_clear)))
                         || (overflow_irq_enable && (ovf_hit
                            || (overflow_flag && !overflow_flag_clear)));
            periodic_irq <= periodic_irq_enable
                         && (pit_rise || (periodic_flag && !periodic_flag_clear));
        end
    end

    // pulse events last one cycle; level event follows a tap of 64..8192
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_event   <= 1'b0;
            overflow_event  <= 1'b0;
            periodic_event  <= 1'b0;
            count_value     <= `RTCPT_CNT_RST;
            counter_running <= 1'b0;
        end else begin
            compare_event   <= cmp_hit;
            overflow_event  <= ovf_hit;
            periodic_event  <= periodic_enable_bit && periodic_event_sel >= `RTCPT_EVT_MIN
                               && periodic_event_sel <= `RTCPT_EVT_MAX
                               && tap_bit(pre_cnt, periodic_event_sel);
            count_value     <= cnt;
            counter_running <= counter_enable_bit;
        end
    end

    // compare flag rises the cycle after a tick at compare value
    compare_flag_a: assert property (@(posedge clk) disable iff (rst)
        cmp_hit |=> compare_flag && compare_event)
        else $error("compare flag missed");

    overflow_wrap_a: assert property (@(posedge clk) disable iff (rst)
        ovf_hit |=> cnt == 16'h0000 && overflow_flag)
        else $error("counter did not wrap on overflow");

    overflow_when_a: assert property (@(posedge clk) disable iff (rst)
        $rose(overflow_event) |-> $past(cnt) == $past(period_value))
        else $error("overflow away from period");

    prescale_off_a: assert property (@(posedge clk) disable iff (rst)
        !pre_run |=> pre_cnt == 15'h0000)
        else $error("prescaler ran while both disabled");

    counter_hold_a: assert property (@(posedge clk) disable iff (rst)
        !counter_enable_bit |=> $stable(cnt) || cnt == 16'h0000)
        else $error("counter moved while disabled");

    // a rise of bit 3 under the sixteen-cycle setting must set the flag
    pit_bit3_a: assert property (@(posedge clk) disable iff (rst)
        periodic_enable_bit && periodic_period_sel == `RTCPT_PER_SIXTEEN_CYCLE_SETTING
        ##1 periodic_enable_bit && periodic_period_sel == `RTCPT_PER_SIXTEEN_CYCLE_SETTING
        && $rose(pre_cnt[3]) |=> periodic_flag)
        else $error("sixteen cycle tap wrong");

    flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
        periodic_flag && !periodic_flag_clear |=> periodic_flag)
        else $error("periodic flag lost");

    irq_follow_a: assert property (@(posedge clk) disable iff (rst)
        periodic_irq_enable && periodic_flag && !periodic_flag_clear
        ##1 periodic_irq_enable |-> periodic_irq)
        else $error("periodic request not held");

    pit_off_a: assert property (@(posedge clk) disable iff (rst)
        !periodic_enable_bit ##1 !periodic_enable_bit |-> !pit_rise)
        else $error("periodic tick while disabled");

    // the extra fast step must never share a cycle with a reference edge
    corr_extra_a: assert property (@(posedge clk) disable iff (rst)
        corr_extra |-> !ref_edge)
        else $error("fast step collided with edge");
endmodule
`default_nettype wire

// ==== rtcpt_params.svh ====
// constants for the counter and periodic tick block
// included by the package and by the top module; definitions only
`ifndef RTCPT_PARAMS_SVH
`define RTCPT_PARAMS_SVH

`define RTCPT_CNT_W        16
`define RTCPT_PRE_W        15
`define RTCPT_PRESC_W      4
`define RTCPT_PERIOD_W     4
`define RTCPT_CAL_W        8
`define RTCPT_CLOCK_SOURCE_SELECT_W     2
`define RTCPT_CNT_RST      16'h0000
`define RTCPT_PER_RST      16'hffff
`define RTCPT_CMP_RST      16'h0000
`define RTCPT_PRE_RST      15'h0000
// correction spread window: one million prescaler input cycles
`define RTCPT_CORR_WIN     20'hf423f
`define RTCPT_CORR_MAX     7'h7f
// periodic setting codes: 1 selects divide by 4 ... 14 selects 32768
`define RTCPT_PER_MIN      4'h1
`define RTCPT_PER_MAX      4'he
`define RTCPT_PER_SIXTEEN_CYCLE_SETTING    4'h3
`define RTCPT_EVT_MIN      4'h5
`define RTCPT_EVT_MAX      4'hc
// low-power oscillator divided by 32
`define RTCPT_OSCDIV       5'h1f

`endif

// ==== rtcpt_pkg.sv ====
// types shared by the counter and periodic tick block
// assumes rtcpt_params.svh is on the include path
`default_nettype none
`include "rtcpt_params.svh"
package rtcpt_pkg;
    typedef enum logic [1:0] {
        RTCPT_SRC_XTAL = 2'h0,
        RTCPT_SRC_EXT  = 2'h1,
        RTCPT_SRC_ULP  = 2'h2,
        RTCPT_SRC_ULP32 = 2'h3
    } rtcpt_src_t;
    // correction sequencer: idle -> applying -> waiting -> idle
    typedef enum logic [1:0] {
        RTCPT_C_IDLE  = 2'b00,
        RTCPT_C_WAIT  = 2'b01,
        RTCPT_C_APPLY = 2'b11
    } rtcpt_corr_t;
endpackage
`default_nettype wire

// ==== rtcpt_sync.sv ====
// two-flop synchroniser for levels from outside the clk domain
// assumes clk is the only clock; reset is asynchronous, active high
`default_nettype none
module rtcpt_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // level in and out
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== rtcpt_top_tb.sv ====
// self-checking bench for the counter and periodic tick block
// assumes rtcpt_pkg and rtcpt_top are compiled first; bench drives every port
`default_nettype none
`include "rtcpt_params.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module rtcpt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rtcpt_pkg::*;

    logic                        clk, rst, xtal_clk, ext_clk, low_power_osc;
    rtcpt_src_t                  clock_source_select;
    logic                        counter_enable_bit, periodic_enable_bit;
    logic [`RTCPT_PRESC_W-1:0]   prescaler_sel;
    logic [`RTCPT_CNT_W-1:0]     compare_value, period_value, count_value, c0, d;
    logic                        compare_irq_enable, overflow_irq_enable, periodic_irq_enable;
    logic                        correction_enable;
    logic [`RTCPT_CAL_W-1:0]     correction_ppm;
    logic [`RTCPT_PERIOD_W-1:0]  periodic_period_sel, periodic_event_sel;
    logic                        compare_flag_clear, overflow_flag_clear, periodic_flag_clear;
    logic                        compare_flag, overflow_flag, periodic_flag;
    logic                        counter_irq, periodic_irq, counter_running;
    logic                        compare_event, overflow_event, periodic_event;
    logic [7:0]                  div;
    int                          fails, samples_checked, t0, cyc;
    rtcpt_src_t                  src_tab [5] = '{RTCPT_SRC_XTAL, RTCPT_SRC_EXT, RTCPT_SRC_ULP,
                                                 RTCPT_SRC_ULP32, RTCPT_SRC_XTAL};
    logic [3:0]                  psc_tab [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
    int                          exp_tab [5] = '{64, 32, 128, 4, 16};

    rtcpt_top i_rtcpt_top (
        .clk(clk), .rst(rst), .xtal_clk(xtal_clk), .ext_clk(ext_clk),
        .low_power_osc(low_power_osc), .clock_source_select(clock_source_select),
        .counter_enable_bit(counter_enable_bit), .prescaler_sel(prescaler_sel),
        .compare_value(compare_value), .period_value(period_value),
        .compare_irq_enable(compare_irq_enable), .overflow_irq_enable(overflow_irq_enable),
        .correction_enable(correction_enable), .correction_ppm(correction_ppm),
        .periodic_enable_bit(periodic_enable_bit), .periodic_period_sel(periodic_period_sel),
        .periodic_event_sel(periodic_event_sel), .periodic_irq_enable(periodic_irq_enable),
        .compare_flag_clear(compare_flag_clear), .overflow_flag_clear(overflow_flag_clear),
        .periodic_flag_clear(periodic_flag_clear), .count_value(count_value),
        .compare_flag(compare_flag), .overflow_flag(overflow_flag),
        .periodic_flag(periodic_flag), .counter_irq(counter_irq),
        .periodic_irq(periodic_irq), .compare_event(compare_event),
        .overflow_event(overflow_event), .periodic_event(periodic_event),
        .counter_running(counter_running)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // source pins: periods of 16, 32 and 8 system clocks, all slow enough to sample
    always @(posedge clk) begin
        div <= div + 8'h01;
        low_power_osc <= div[2];
        xtal_clk <= div[3];
        ext_clk <= div[4];
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return compare_flag;
            1: return overflow_flag;
            2: return periodic_flag;
            3: return periodic_event;
            4: return ~periodic_event;
            default: return overflow_event;
        endcase
    endfunction

    function automatic logic in_tol(input int got, input int want, input int tol);
        return (got >= want - tol) && (got <= want + tol);
    endfunction

    // every wait is bounded; running out ends the run as a mismatch
    task automatic wait_on(input int w, input int bound);
        int n;
        n = 0;
        while (pick(w) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > bound) begin
                fails++;
                $display("[FAIL] %0t wait on %0d timed out", $time, w);
                finish_test();
            end
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic clr(input int w);
        @(posedge clk);
        compare_flag_clear <= (w == 0);
        overflow_flag_clear <= (w == 1);
        periodic_flag_clear <= (w == 2);
        @(posedge clk);
        {compare_flag_clear, overflow_flag_clear, periodic_flag_clear} <= 3'h0;
        @(negedge clk);
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
    endtask

    initial begin
        rst = 1'b1;
        div = 8'h00;
        {xtal_clk, ext_clk, low_power_osc} = 3'h0;
        clock_source_select = RTCPT_SRC_XTAL;
        {counter_enable_bit, periodic_enable_bit, correction_enable} = 3'h0;
        {compare_irq_enable, overflow_irq_enable, periodic_irq_enable} = 3'h0;
        {compare_flag_clear, overflow_flag_clear, periodic_flag_clear} = 3'h0;
        prescaler_sel = 4'h0;
        compare_value = 16'h0000;
        period_value = 16'hffff;
        correction_ppm = 8'h00;
        periodic_period_sel = 4'h0;
        periodic_event_sel = 4'h0;
        fails = 0;
        samples_checked = 0;
        do_reset();
        `CHK({count_value, compare_flag, overflow_flag, counter_running}, 19'h0)
        // each source and a prescaler setting against the expected tick rate
        for (int s = 0; s < 5; s++) begin
            @(posedge clk);
            counter_enable_bit <= 1'b0;
            clock_source_select <= src_tab[s];
            prescaler_sel <= psc_tab[s];
            @(posedge clk);
            counter_enable_bit <= 1'b1;
            tick(300);
            c0 = count_value;
            tick(1024);
            d = count_value - c0;
            `CHK(in_tol(int'(d), exp_tab[s], 1), 1'b1)
        end
        @(posedge clk);
        counter_enable_bit <= 1'b0;
        tick(8);
        `CHK(counter_running, 1'b0)
        c0 = count_value;
        tick(256);
        `CHK(count_value, c0)
        // compare at 5, wrap at 9, one ref clock per count
        do_reset();
        @(posedge clk);
        clock_source_select <= RTCPT_SRC_XTAL;
        prescaler_sel <= 4'h0;
        compare_value <= 16'h0005;
        period_value <= 16'h0009;
        compare_irq_enable <= 1'b1;
        @(posedge clk);
        counter_enable_bit <= 1'b1;
        wait_on(0, 400);
        tick(3);
        `CHK(count_value, 16'h0006)
        `CHK(counter_irq, 1'b1)
        wait_on(5, 400);
        tick(1);
        `CHK(overflow_event, 1'b0)
        `CHK(overflow_flag, 1'b1)
        tick(2);
        `CHK(count_value, 16'h0000)
        t0 = $time;
        wait_on(5, 400);
        cyc = ($time - t0) / 4 + 3;
        `CHK(in_tol(cyc, 160, 1), 1'b1)
        clr(0);
        `CHK({compare_flag, overflow_flag, counter_irq}, 3'b010)
        @(posedge clk);
        overflow_irq_enable <= 1'b1;
        tick(2);
        `CHK(counter_irq, 1'b1)
        @(posedge clk);
        counter_enable_bit <= 1'b0;
        clr(1);
        `CHK({overflow_flag, counter_irq}, 2'b00)
        // correction over eight crystal periods: fast gains a count, slow loses one
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            correction_enable <= 1'b0;
            do_reset();
            @(posedge clk);
            period_value <= 16'hffff;
            @(posedge clk);
            counter_enable_bit <= 1'b1;
            tick(64);
            c0 = count_value;
            @(posedge clk);
            correction_enable <= 1'b1;
            correction_ppm <= (m == 0) ? 8'h03 : 8'hfd;
            tick(127);
            d = count_value - c0;
            `CHK(d, (m == 0) ? 16'h0009 : 16'h0007)
        end
        @(posedge clk);
        {counter_enable_bit, correction_enable} <= 2'h0;
        do_reset();
        // periodic tick alone, counter off, divide by 4, 8 and 16
        for (int k = 1; k <= 3; k++) begin
            @(posedge clk);
            periodic_irq_enable <= 1'b1;
            periodic_period_sel <= k[3:0];
            @(posedge clk);
            periodic_enable_bit <= 1'b1;
            wait_on(2, 2100);
            clr(2);
            t0 = $time;
            wait_on(2, 2100);
            cyc = ($time - t0) / 4 + 2;
            `CHK(in_tol(cyc, 16 << (k + 1), 2), 1'b1)
            `CHK(periodic_irq, 1'b1)
            clr(2);
        end
        // level events: high for half the period, ref of 8 clocks
        @(posedge clk);
        periodic_enable_bit <= 1'b0;
        @(posedge clk);
        clock_source_select <= RTCPT_SRC_ULP;
        @(posedge clk);
        periodic_enable_bit <= 1'b1;
        for (int e = 5; e <= 8; e++) begin
            @(posedge clk);
            periodic_event_sel <= e[3:0];
            wait_on(4, 9000);
            wait_on(3, 9000);
            t0 = $time;
            wait_on(4, 9000);
            cyc = ($time - t0) / 4;
            `CHK(in_tol(cyc, 8 << e, 2), 1'b1)
        end
        // both functions off: prescaler cleared, no further ticks
        @(posedge clk);
        periodic_enable_bit <= 1'b0;
        clr(2);
        tick(1200);
        `CHK({periodic_flag, periodic_irq}, 2'b00)
        `CHK(periodic_event, 1'b0)
        finish_test();
    end
endmodule
`default_nettype wire
